//--- dcc_defs.svh
// register offsets, field positions and reset values of the comparator block
`ifndef DCC_DEFS_SVH
`define DCC_DEFS_SVH
`define DCC_OFF_CTRL1 8'h00
`define DCC_OFF_CTRL2 8'h04
`define DCC_OFF_STAT 8'h08
`define DCC_OFF_REF 8'h0c
`define DCC_OFF_IRQ_STAT 8'h10
`define DCC_OFF_IRQ_MASK 8'h14
`define DCC_BIT_EN 15
`define DCC_BIT_OE 14
`define DCC_BIT_INV 13
`define DCC_BIT_LP 12
`define DCC_BIT_EVT 9
`define DCC_BIT_OUT 8
`define DCC_BIT_EDGE_HI 7
`define DCC_BIT_EDGE_LO 6
`define DCC_BIT_NINV 4
`define DCC_BIT_CH_HI 1
`define DCC_BIT_CH_LO 0
`define DCC_BIT_IDLE 15
`define DCC_CTRL_WMASK 16'hf2d3
`define DCC_REF_WMASK 16'h00ff
`define DCC_RESET_VAL 16'h0000
`endif

//--- dcc_pkg.sv
// types shared by the comparator control block
package dcc_pkg;
   typedef enum logic [1:0] {DCC_EDGE_OFF, DCC_EDGE_RISE, DCC_EDGE_FALL, DCC_EDGE_ANY} dcc_edge_t;
   typedef enum logic [1:0] {DCC_BW_IDLE, DCC_BW_RESP} dcc_wstate_t;
endpackage : dcc_pkg

//--- dcc_top.sv
// dual comparator control, status, events and axi4-lite register slave
// Overview of operation
// - enable bit turns each comparator on; reset value zero
// - pin output enable drives unsynchronised comparator result, after invert, onto its pin
// - invert bit flips result before reporting and event detection
// - low-power bit selects comparator low-power mode
// - result bit is read-only, polarity follows invert bit
// - event flag set on chosen event; blocks further triggers while set
// - edge code 11 any change, 10 falling, 01 rising (after invert)
// - edge code 00 generates no trigger, event or interrupt
// - non-inverting input selects internal reference or pin A
// - inverting input code selects half bandgap, pin D, C or B
// - idle stop masks comparator interrupts in idle, comparators stay on
// - status bits 9 and 8 mirror the event flags
// - status bits 1 and 0 mirror the compare results
// - unimplemented bits read zero and ignore writes
// - reference offers two ranges of 16 levels, range and source selectable
`include "dcc_defs.svh"
module dcc_top (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // axi4-lite write
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // axi4-lite read
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // analog side
   input wire logic [1:0] cmp_raw,
   input wire logic cpu_idle,
   output logic [1:0] cmp_enable,
   output logic [1:0] low_power_select,
   output logic [1:0] noninv_input_select,
   output logic [3:0] inv_input_select,
   output logic [1:0] result_pin,
   output logic [1:0] result_pin_oe,
   output logic reference_range_select,
   output logic reference_source_select,
   output logic [3:0] reference_level_select,
   output logic [1:0] cmp_trigger,
   output logic irq
);
   import dcc_pkg::*;

   logic [15:0] ctrl_q [2];
   logic [15:0] ctrl_d [2];
   logic idle_stop_q, idle_stop_d;
   logic [7:0] ref_q, ref_d;
   logic [1:0] irq_stat_q, irq_stat_d;
   logic [1:0] irq_mask_q, irq_mask_d;
   logic [1:0] sync1_q, sync2_q, prev_q;
   logic [1:0] sync1_d, sync2_d, prev_d;
   logic [1:0] pol_res;
   dcc_wstate_t wst_q, wst_d;
   logic [7:0] waddr_q, waddr_d;
   logic [31:0] wdata_q, wdata_d;
   logic aw_have_q, aw_have_d, w_have_q, w_have_d;
   logic rvalid_q, rvalid_d;
   logic [31:0] rdata_q, rdata_d;
   logic [1:0] rresp_q, rresp_d;
   logic do_write;
   logic wr_ok;

   function automatic logic mapped(input logic [7:0] a);
      mapped = (a == `DCC_OFF_CTRL1) || (a == `DCC_OFF_CTRL2) || (a == `DCC_OFF_STAT) ||
         (a == `DCC_OFF_REF) || (a == `DCC_OFF_IRQ_STAT) || (a == `DCC_OFF_IRQ_MASK);
   endfunction : mapped

   // two-stage synchroniser, then one register of history
   always_comb begin
      sync1_d = cmp_raw;
      sync2_d = sync1_q;
      prev_d = pol_res;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sync1_q <= 2'h0;
         sync2_q <= 2'h0;
         prev_q <= 2'h0;
      end else begin
         sync1_q <= sync1_d;
         sync2_q <= sync2_d;
         prev_q <= prev_d;
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++) begin : g_cmp
         dcc_edge_t edge_sel;
         logic en;
         logic hit;
         assign en = ctrl_q[gi][`DCC_BIT_EN];
         assign edge_sel = dcc_edge_t'(ctrl_q[gi][`DCC_BIT_EDGE_HI:`DCC_BIT_EDGE_LO]);
         // disabled comparator reads low
         assign pol_res[gi] = en & (sync2_q[gi] ^ ctrl_q[gi][`DCC_BIT_INV]);
         always_comb begin
            case (edge_sel)
               DCC_EDGE_ANY: hit = pol_res[gi] != prev_q[gi];
               DCC_EDGE_FALL: hit = prev_q[gi] & ~pol_res[gi];
               DCC_EDGE_RISE: hit = ~prev_q[gi] & pol_res[gi];
               default: hit = 1'b0;
            endcase
         end
         assign cmp_enable[gi] = en;
         assign low_power_select[gi] = ctrl_q[gi][`DCC_BIT_LP];
         assign noninv_input_select[gi] = ctrl_q[gi][`DCC_BIT_NINV];
         assign inv_input_select[2*gi+1:2*gi] =
            ctrl_q[gi][`DCC_BIT_CH_HI:`DCC_BIT_CH_LO];
         // unsynchronised result, after invert, straight to the pin
         assign result_pin[gi] = en & (cmp_raw[gi] ^ ctrl_q[gi][`DCC_BIT_INV]);
         assign result_pin_oe[gi] = en & ctrl_q[gi][`DCC_BIT_OE];
         // trigger only while flag clear
         assign cmp_trigger[gi] = hit & ~ctrl_q[gi][`DCC_BIT_EVT];
      end
   endgenerate

   assign reference_range_select = ref_q[5];
   assign reference_source_select = ref_q[4];
   assign reference_level_select = ref_q[3:0];

   // write and read channel handshake outputs
   assign s_axi_awready = (wst_q == DCC_BW_IDLE) && !aw_have_q;
   assign s_axi_wready = (wst_q == DCC_BW_IDLE) && !w_have_q;
   assign s_axi_bvalid = (wst_q == DCC_BW_RESP);
   assign s_axi_bresp = wr_ok ? 2'h0 : 2'h2;
   assign wr_ok = mapped(waddr_q);
   assign s_axi_arready = !rvalid_q;
   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rdata = rdata_q;
   assign s_axi_rresp = rresp_q;

   always_comb begin
      logic [15:0] wv;
      wv = 16'h0000;
      wst_d = wst_q;
      waddr_d = waddr_q;
      wdata_d = wdata_q;
      aw_have_d = aw_have_q;
      w_have_d = w_have_q;
      do_write = 1'b0;
      if (s_axi_awvalid && s_axi_awready) begin
         waddr_d = s_axi_awaddr;
         aw_have_d = 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         wv[7:0] = s_axi_wstrb[0] ? s_axi_wdata[7:0] : 8'h00;
         wv[15:8] = s_axi_wstrb[1] ? s_axi_wdata[15:8] : 8'h00;
         wdata_d = {s_axi_wstrb, 12'h000, wv};
         w_have_d = 1'b1;
      end
      case (wst_q)
         DCC_BW_IDLE: begin
            if (aw_have_q && w_have_q) begin
               do_write = 1'b1;
               wst_d = DCC_BW_RESP;
            end
         end
         DCC_BW_RESP: begin
            if (s_axi_bready) begin
               wst_d = DCC_BW_IDLE;
               aw_have_d = 1'b0;
               w_have_d = 1'b0;
            end
         end
         default: wst_d = DCC_BW_IDLE;
      endcase
   end

   // register file next state
   always_comb begin
      logic [15:0] wmask;
      logic [15:0] wd;
      wmask = {{8{wdata_q[29]}}, {8{wdata_q[28]}}};
      wd = wdata_q[15:0];
      ctrl_d[0] = ctrl_q[0];
      ctrl_d[1] = ctrl_q[1];
      idle_stop_d = idle_stop_q;
      ref_d = ref_q;
      irq_mask_d = irq_mask_q;
      irq_stat_d = irq_stat_q;
      for (int i = 0; i < 2; i++) begin
         if (do_write && waddr_q == (i == 0 ? `DCC_OFF_CTRL1 : `DCC_OFF_CTRL2)) begin
            ctrl_d[i] = (ctrl_q[i] & ~(wmask & `DCC_CTRL_WMASK)) |
               (wd & wmask & `DCC_CTRL_WMASK);
         end
         // set wins over software clear
         if (cmp_trigger[i]) begin
            ctrl_d[i][`DCC_BIT_EVT] = 1'b1;
         end
         ctrl_d[i][`DCC_BIT_OUT] = 1'b0;
      end
      if (do_write && waddr_q == `DCC_OFF_STAT && wmask[15]) begin
         idle_stop_d = wd[`DCC_BIT_IDLE];
      end
      if (do_write && waddr_q == `DCC_OFF_REF && wmask[0]) begin
         ref_d = 8'(wd & `DCC_REF_WMASK);
      end
      if (do_write && waddr_q == `DCC_OFF_IRQ_MASK && wmask[0]) begin
         irq_mask_d = wd[1:0];
      end
      if (do_write && waddr_q == `DCC_OFF_IRQ_STAT && wmask[0]) begin
         irq_stat_d = irq_stat_q & ~wd[1:0];
      end
      irq_stat_d = irq_stat_d | cmp_trigger;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_q[0] <= `DCC_RESET_VAL;
         ctrl_q[1] <= `DCC_RESET_VAL;
         idle_stop_q <= 1'b0;
         ref_q <= 8'h00;
         irq_mask_q <= 2'h0;
         irq_stat_q <= 2'h0;
         wst_q <= DCC_BW_IDLE;
         waddr_q <= 8'h00;
         wdata_q <= 32'h0;
         aw_have_q <= 1'b0;
         w_have_q <= 1'b0;
      end else begin
         ctrl_q[0] <= ctrl_d[0];
         ctrl_q[1] <= ctrl_d[1];
         idle_stop_q <= idle_stop_d;
         ref_q <= ref_d;
         irq_mask_q <= irq_mask_d;
         irq_stat_q <= irq_stat_d;
         wst_q <= wst_d;
         waddr_q <= waddr_d;
         wdata_q <= wdata_d;
         aw_have_q <= aw_have_d;
         w_have_q <= w_have_d;
      end
   end

   // read data
   always_comb begin
      logic [15:0] rv;
      rv = 16'h0000;
      rvalid_d = rvalid_q;
      rdata_d = rdata_q;
      rresp_d = rresp_q;
      if (rvalid_q && s_axi_rready) begin
         rvalid_d = 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
         case (s_axi_araddr)
            `DCC_OFF_CTRL1: rv = ctrl_q[0] | {7'h00, pol_res[0], 8'h00};
            `DCC_OFF_CTRL2: rv = ctrl_q[1] | {7'h00, pol_res[1], 8'h00};
            `DCC_OFF_STAT: rv = {idle_stop_q, 5'h00, ctrl_q[1][`DCC_BIT_EVT],
               ctrl_q[0][`DCC_BIT_EVT], 6'h00, pol_res};
            `DCC_OFF_REF: rv = {8'h00, ref_q};
            `DCC_OFF_IRQ_STAT: rv = {14'h0000, irq_stat_q};
            `DCC_OFF_IRQ_MASK: rv = {14'h0000, irq_mask_q};
            default: rv = 16'h0000;
         endcase
         rdata_d = {16'h0000, rv};
         rresp_d = mapped(s_axi_araddr) ? 2'h0 : 2'h2;
         rvalid_d = 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_q <= 1'b0;
         rdata_q <= 32'h0;
         rresp_q <= 2'h0;
      end else begin
         rvalid_q <= rvalid_d;
         rdata_q <= rdata_d;
         rresp_q <= rresp_d;
      end
   end

   // interrupts blocked in idle when idle stop is set
   assign irq = |(irq_stat_q & irq_mask_q) & ~(idle_stop_q & cpu_idle);

   // assertions
   property p_flag_sets;
      @(posedge aclk) disable iff (!aresetn)
         cmp_trigger[0] |=> ctrl_q[0][`DCC_BIT_EVT];
   endproperty
   a_flag_sets: assert property (p_flag_sets) else $error("event flag not set");
   property p_no_trig_flag;
      @(posedge aclk) disable iff (!aresetn)
         ctrl_q[1][`DCC_BIT_EVT] |-> !cmp_trigger[1];
   endproperty
   a_no_trig_flag: assert property (p_no_trig_flag) else $error("trigger while flagged");
   property p_off_code;
      @(posedge aclk) disable iff (!aresetn)
         ctrl_q[0][7:6] == 2'h0 |-> !cmp_trigger[0];
   endproperty
   a_off_code: assert property (p_off_code) else $error("trigger with edge off");
   property p_rise;
      @(posedge aclk) disable iff (!aresetn)
         (ctrl_q[0][7:6] == 2'h1 && !ctrl_q[0][9] && pol_res[0] && !prev_q[0])
         |-> cmp_trigger[0];
   endproperty
   a_rise: assert property (p_rise) else $error("rising edge missed");
   property p_sync;
      @(posedge aclk) disable iff (!aresetn)
         (ctrl_q[1][15] && $stable(ctrl_q[1])) |-> pol_res[1] == (sync2_q[1] ^ ctrl_q[1][13]);
   endproperty
   a_sync: assert property (p_sync) else $error("result mismatch");
   property p_oe;
      @(posedge aclk) disable iff (!aresetn)
         !ctrl_q[0][15] |-> !result_pin_oe[0] && !cmp_enable[0];
   endproperty
   a_oe: assert property (p_oe) else $error("pin driven while off");
   property p_idle;
      @(posedge aclk) disable iff (!aresetn)
         (idle_stop_q && cpu_idle) |-> !irq;
   endproperty
   a_idle: assert property (p_idle) else $error("irq in idle stop");
   property p_stat_read;
      @(posedge aclk) disable iff (!aresetn)
         (s_axi_arvalid && s_axi_arready && s_axi_araddr == `DCC_OFF_STAT)
         |=> s_axi_rvalid && s_axi_rdata[14:10] == 5'h00 && s_axi_rdata[7:2] == 6'h00;
   endproperty
   a_stat_read: assert property (p_stat_read) else $error("reserved bits set");
   property p_flag_sets2;
      @(posedge aclk) disable iff (!aresetn)
         cmp_trigger[1] |=> ctrl_q[1][`DCC_BIT_EVT];
   endproperty
   a_flag_sets2: assert property (p_flag_sets2) else $error("event flag 2 not set");
   property p_fall;
      @(posedge aclk) disable iff (!aresetn)
         (ctrl_q[0][7:6] == 2'h2 && !ctrl_q[0][9] && !pol_res[0] && prev_q[0])
         |-> cmp_trigger[0];
   endproperty
   a_fall: assert property (p_fall) else $error("falling edge missed");
   property p_any;
      @(posedge aclk) disable iff (!aresetn)
         (ctrl_q[0][7:6] == 2'h3 && !ctrl_q[0][9] && pol_res[0] != prev_q[0])
         |-> cmp_trigger[0];
   endproperty
   a_any: assert property (p_any) else $error("change missed");
   sequence s_stat_req;
      s_axi_arvalid && s_axi_arready && s_axi_araddr == `DCC_OFF_STAT;
   endsequence
   sequence s_stat_data;
      s_axi_rvalid && s_axi_rdata[1:0] == $past(pol_res) &&
         s_axi_rdata[9] == $past(ctrl_q[1][`DCC_BIT_EVT]) &&
         s_axi_rdata[8] == $past(ctrl_q[0][`DCC_BIT_EVT]);
   endsequence
   property p_stat_mirror;
      @(posedge aclk) disable iff (!aresetn)
         s_stat_req |=> s_stat_data;
   endproperty
   a_stat_mirror: assert property (p_stat_mirror) else $error("status mirror wrong");
   property p_res_read;
      @(posedge aclk) disable iff (!aresetn)
         (s_axi_arvalid && s_axi_arready && s_axi_araddr == `DCC_OFF_CTRL1)
         |=> s_axi_rdata[`DCC_BIT_OUT] == $past(pol_res[0]);
   endproperty
   a_res_read: assert property (p_res_read) else $error("result bit wrong");
   property p_pin;
      @(posedge aclk) disable iff (!aresetn)
         result_pin_oe[0] |-> result_pin[0] == (cmp_raw[0] ^ ctrl_q[0][`DCC_BIT_INV]);
   endproperty
   a_pin: assert property (p_pin) else $error("pin value wrong");
   property p_irq_level;
      @(posedge aclk) disable iff (!aresetn)
         !(idle_stop_q && cpu_idle) |-> irq == |(irq_stat_q & irq_mask_q);
   endproperty
   a_irq_level: assert property (p_irq_level) else $error("irq level wrong");
   property p_sync_delay;
      @(posedge aclk) disable iff (!aresetn)
         ($past(aresetn) && $past(aresetn, 2) && ctrl_q[0][`DCC_BIT_EN])
         |-> pol_res[0] == ($past(cmp_raw[0], 2) ^ ctrl_q[0][`DCC_BIT_INV]);
   endproperty
   a_sync_delay: assert property (p_sync_delay) else $error("synchroniser depth wrong");
endmodule : dcc_top

//--- dcc_analog_model.sv
// behavioural model of the two analog comparators feeding the block
module dcc_analog_model (
   // clock
   input wire logic aclk,
   // commanded comparator levels and response speed
   input wire logic [1:0] level,
   input wire logic slow,
   // raw comparator outputs
   output logic [1:0] cmp_raw
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] lag_q;
   // a slow comparator settles one clock later than commanded
   always_ff @(posedge aclk) begin
      lag_q <= level;
   end
   assign cmp_raw = slow ? lag_q : level;
endmodule : dcc_analog_model

//--- tb_top.sv
// self-checking bench for the dual comparator control block
`include "dcc_defs.svh"
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct {logic [7:0] a; logic [15:0] w; logic [15:0] e; logic [1:0] s;} dcc_row_t;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [7:0] awa = 8'h00;
   logic [7:0] ara = 8'h00;
   logic [31:0] wd = 32'h0;
   logic [3:0] ws = 4'hf;
   logic awv = 1'b0, wv = 1'b0, bre = 1'b0, arv = 1'b0, rre = 1'b0;
   logic idle = 1'b0, slow = 1'b0;
   logic [1:0] lvl = 2'b00;
   logic awr, wr, bv, arr, rv, irq, rrs, rss, iv, er, ef;
   logic [1:0] br, rr, raw, en, lp, ni, pin, oe, trig, resp, c;
   logic [3:0] ii, rl;
   logic [15:0] cw;
   logic [31:0] rd, v;
   int num_errors = 0, cmp_count = 0, trig_cnt = 0, i, k, n0;
   dcc_row_t rows [6] = '{'{`DCC_OFF_CTRL1, 16'h7dff, 16'h70d3, 2'h0},
      '{`DCC_OFF_CTRL2, 16'h7dff, 16'h70d3, 2'h0}, '{`DCC_OFF_REF, 16'hffff, 16'h00ff, 2'h0},
      '{`DCC_OFF_STAT, 16'hffff, 16'h8000, 2'h0}, '{`DCC_OFF_IRQ_MASK, 16'hffff, 16'h0003, 2'h0},
      '{8'h18, 16'hffff, 16'h0000, 2'h2}};
   dcc_top u_dcc_top (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
      .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv),
      .s_axi_wready(wr), .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bre),
      .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd),
      .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rre), .cmp_raw(raw), .cpu_idle(idle),
      .cmp_enable(en), .low_power_select(lp), .noninv_input_select(ni), .inv_input_select(ii),
      .result_pin(pin), .result_pin_oe(oe), .reference_range_select(rrs),
      .reference_source_select(rss), .reference_level_select(rl), .cmp_trigger(trig), .irq(irq));
   dcc_analog_model u_dcc_analog_model (.aclk(aclk), .level(lvl), .slow(slow), .cmp_raw(raw));
   always #20 aclk = ~aclk;
   always @(posedge aclk) trig_cnt <= trig_cnt + trig[0] + trig[1];
   task chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         num_errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task end_sim;
      $display("compares %0d mismatches %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : end_sim
   task tmo;
      num_errors++;
      $display("Error at %0t: bus wait ran out", $time);
      end_sim();
   endtask : tmo
   task cyc(input int n);
      repeat (n) @(posedge aclk);
   endtask : cyc
   task automatic axw(input logic [7:0] a, input logic [15:0] d);
      int n;
      logic ta, tw, tk;
      @(posedge aclk);
      awa <= a;
      wd <= {16'h0000, d};
      awv <= 1'b1;
      wv <= 1'b1;
      bre <= 1'b1;
      for (n = 0; n < 40; n++) begin
         @(negedge aclk);
         ta = awv & awr;
         tw = wv & wr;
         tk = bv;
         resp = br;
         @(posedge aclk);
         if (ta) awv <= 1'b0;
         if (tw) wv <= 1'b0;
         if (tk) break;
      end
      bre <= 1'b0;
      if (n == 40) tmo();
   endtask : axw
   task automatic rchk(input logic [7:0] a, input logic [15:0] e);
      int n;
      logic ta, tk;
      @(posedge aclk);
      ara <= a;
      arv <= 1'b1;
      rre <= 1'b1;
      for (n = 0; n < 40; n++) begin
         @(negedge aclk);
         ta = arv & arr;
         tk = rv;
         v = rd;
         resp = rr;
         @(posedge aclk);
         if (ta) arv <= 1'b0;
         if (tk) break;
      end
      rre <= 1'b0;
      if (n == 40) tmo();
      chk(v, {16'h0000, e});
   endtask : rchk
   task clr(input logic [7:0] a, input logic [15:0] w);
      axw(a, w);
      axw(`DCC_OFF_IRQ_STAT, 16'h0003);
   endtask : clr
   initial begin
      cyc(6);
      aresetn <= 1'b1;
      for (i = 0; i < 6; i++) rchk(8'(i * 4), 16'h0000);
      $display("reset value test done");
      for (i = 0; i < 6; i++) begin
         axw(rows[i].a, rows[i].w);
         chk(resp, rows[i].s);
         rchk(rows[i].a, rows[i].e);
         chk(resp, rows[i].s);
      end
      chk(32'({lp, ni, ii, en, oe, rrs, rss, rl}), 32'h0003fc3f);
      for (i = 0; i < 6; i++) axw(rows[i].a, 16'h0000);
      ws <= 4'h1;
      axw(`DCC_OFF_CTRL2, 16'hffff);
      ws <= 4'hf;
      rchk(`DCC_OFF_CTRL2, 16'h00d3);
      axw(`DCC_OFF_CTRL2, 16'h0000);
      $display("register table test done");
      lvl <= 2'b11;
      axw(`DCC_OFF_CTRL1, 16'hd002);
      axw(`DCC_OFF_CTRL2, 16'h8011);
      chk(32'({en, oe, lp, ni, ii, pin}), 32'h0000359b);
      for (i = 0; i < 4; i++) begin
         axw(`DCC_OFF_CTRL1, 16'h8000 | 16'(i));
         chk(ii[1:0], i[1:0]);
      end
      axw(`DCC_OFF_CTRL2, 16'h0000);
      axw(`DCC_OFF_IRQ_MASK, 16'h0001);
      lvl <= 2'b00;
      $display("output select test done");
      for (k = 0; k < 8; k++) begin
         c = k[1:0];
         iv = k[2];
         slow <= iv;
         cw = {2'b10, iv, 5'b00000, c, 6'b000000};
         er = (c == 2'b11) || (c == {iv, ~iv});
         ef = (c == 2'b11) || (c == {~iv, iv});
         axw(`DCC_OFF_CTRL1, cw);
         cyc(6);
         clr(`DCC_OFF_CTRL1, cw);
         n0 = trig_cnt;
         lvl <= 2'b01;
         cyc(6);
         rchk(`DCC_OFF_STAT, {7'h00, er, 7'h00, ~iv});
         chk({oe[0], pin[0]}, {30'h0, 1'b0, ~iv});
         chk(irq, er);
         chk(trig_cnt - n0, er);
         clr(`DCC_OFF_CTRL1, cw);
         lvl <= 2'b00;
         cyc(6);
         rchk(`DCC_OFF_STAT, {7'h00, ef, 7'h00, iv});
         chk(irq, ef);
      end
      $display("event code test done");
      axw(`DCC_OFF_CTRL1, 16'h0000);
      axw(`DCC_OFF_IRQ_MASK, 16'h0003);
      axw(`DCC_OFF_STAT, 16'h8000);
      axw(`DCC_OFF_CTRL2, 16'h80c0);
      cyc(6);
      clr(`DCC_OFF_CTRL2, 16'h80c0);
      idle <= 1'b1;
      lvl <= 2'b10;
      cyc(6);
      rchk(`DCC_OFF_STAT, 16'h8202);
      chk(irq, 1'b0);
      idle <= 1'b0;
      cyc(2);
      chk(irq, 1'b1);
      axw(`DCC_OFF_IRQ_STAT, 16'h0003);
      n0 = trig_cnt;
      lvl <= 2'b00;
      cyc(6);
      chk(irq, 1'b0);
      chk(trig_cnt - n0, 0);
      rchk(`DCC_OFF_STAT, 16'h8200);
      axw(`DCC_OFF_CTRL2, 16'h80c0);
      rchk(`DCC_OFF_STAT, 16'h8000);
      $display("idle and suppression test done");
      aresetn <= 1'b0;
      cyc(6);
      aresetn <= 1'b1;
      rchk(`DCC_OFF_CTRL2, 16'h0000);
      chk(en, 2'b00);
      $display("second reset test done");
      end_sim();
   end
endmodule : tb_top
